/* src/typec_detector_i2c_registers.sv */
/*
  Two-wire serial slave and register bank of a Type-C plug-in detector:
  identification, port control and clear-on-read attach/detach events.
  Assumes bus pins and the address strap are asynchronous to clk; the
  connection state arrives from detection logic clocked by linkClk.
*/
`timescale 1ns/10ps
module typec_detector_i2c_registers (
  input wire logic clk,
  input wire logic rstn,
  input wire logic linkClk,
  input wire logic sclIn,
  input wire logic sdaIn,
  output logic sdaOut,
  output logic sdaOe,
  input wire logic addressSelect,
  input wire logic portAttached,
  input wire logic [7:0] ccStatus,
  output logic interrupt_request_line_out,
  output logic interrupt_request_line_oe,
  output logic lowPower,
  output logic ccPulldownOnly,
  output logic trySinkPreferred,
  output logic accessoryDetectEnable,
  output logic [1:0] sourceCurrent,
  output logic [1:0] portRole
);

  typedef enum logic [2:0] {
    IDLE = 3'b000,
    ADDR = 3'b001,
    ADDR_ACK = 3'b010,
    WRITE = 3'b011,
    WRITE_ACK = 3'b100,
    READ = 3'b101,
    READ_ACK = 3'b110
  } bus_state_type;

  // ----------------------------------------------------------------------
  // link side: attach/detach edges become toggles
  // ----------------------------------------------------------------------
  logic attachedPrev;
  logic attachToggle;
  logic detachToggle;
  always_ff @(posedge linkClk or negedge rstn) begin
    if (!rstn) begin
      attachedPrev <= 1'b0;
      attachToggle <= 1'b0;
      detachToggle <= 1'b0;
    end else begin
      attachedPrev <= portAttached;
      if (portAttached && !attachedPrev) begin
        attachToggle <= !attachToggle;
      end
      if (!portAttached && attachedPrev) begin
        detachToggle <= !detachToggle;
      end
    end
  end

  // ----------------------------------------------------------------------
  // crossing into clk: pins, strap and event toggles
  // ----------------------------------------------------------------------
  logic [4:0] syncIn;
  logic [4:0] synced;
  logic sclPrev;
  logic sdaPrev;
  logic attachPrevTog;
  logic detachPrevTog;

  assign syncIn = {detachToggle, attachToggle, addressSelect, sdaIn, sclIn};
  sync_two_flop #(.WIDTH(5)) pinSync (
    .clk(clk),
    .rstn(rstn),
    .asyncIn(syncIn),
    .syncOut(synced)
  );
  wire scl = synced[0];
  wire sda = synced[1];
  wire addrHigh = synced[2];
  wire sclRise = scl && !sclPrev;
  wire sclFall = !scl && sclPrev;
  wire startDet = scl && sclPrev && sdaPrev && !sda;
  wire stopDet = scl && sclPrev && !sdaPrev && sda;
  wire attachEvent = synced[3] ^ attachPrevTog;
  wire detachEvent = synced[4] ^ detachPrevTog;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sclPrev <= 1'b1;
      sdaPrev <= 1'b1;
      attachPrevTog <= 1'b0;
      detachPrevTog <= 1'b0;
    end else begin
      sclPrev <= scl;
      sdaPrev <= sda;
      attachPrevTog <= synced[3];
      detachPrevTog <= synced[4];
    end
  end

  // ----------------------------------------------------------------------
  // registers and read selection
  // ----------------------------------------------------------------------
  bus_state_type state;
  logic [3:0] bitCnt;
  logic [7:0] shift;
  logic [2:0] ptr;
  logic readMode;
  logic [7:0] control;
  logic [1:0] events;
  logic [7:0] rdData;
  wire [6:0] myAddr = addrHigh ?
    typec_regs_pkg::SLAVE_ADDR_HIGH : typec_regs_pkg::SLAVE_ADDR_LOW;
  wire [7:0] idValue = {typec_regs_pkg::ID_CHIP_CODE,
                        typec_regs_pkg::ID_VERSION_CODE,
                        typec_regs_pkg::ID_VENDOR_CODE};
  wire byteDone = bitCnt == typec_regs_pkg::BITS_PER_BYTE;
  wire addrMatch = shift[7:1] == myAddr;
  wire writeCommit = sclFall && state == WRITE && byteDone;
  wire loadByte = sclFall && ((state == ADDR_ACK && readMode) ||
                              (state == READ_ACK));
  wire readNack = sclRise && state == READ_ACK && sda;
  wire eventsRead = loadByte &&
                    ptr == typec_regs_pkg::IDX_ATTACH_DETACH_EVENTS;

  // reads past the status byte return zero; the pointer saturates
  always_comb begin
    case (ptr)
      typec_regs_pkg::IDX_CHIP_IDENTIFICATION: rdData = idValue;
      typec_regs_pkg::IDX_PORT_CONTROL: rdData = control;
      typec_regs_pkg::IDX_ATTACH_DETACH_EVENTS:
        rdData = {6'h00, events};
      typec_regs_pkg::IDX_CC_STATUS: rdData = ccStatus;
      default: rdData = 8'h00;
    endcase
  end
  wire [2:0] ptrNext = (ptr == typec_regs_pkg::IDX_LAST) ? ptr
                                                         : ptr + 3'h1;

  // ----------------------------------------------------------------------
  // bus protocol engine
  // ----------------------------------------------------------------------
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state <= IDLE;
      bitCnt <= 4'h0;
      shift <= 8'h00;
      ptr <= typec_regs_pkg::IDX_CHIP_IDENTIFICATION;
      readMode <= 1'b0;
      sdaOe <= 1'b0;
    end else if (startDet) begin
      state <= ADDR;
      bitCnt <= 4'h0;
      ptr <= typec_regs_pkg::IDX_CHIP_IDENTIFICATION;
      sdaOe <= 1'b0;
    end else if (stopDet) begin
      state <= IDLE;
      sdaOe <= 1'b0;
    end else begin
      case (state)
        IDLE: sdaOe <= 1'b0;
        ADDR, WRITE: begin
          if (sclRise && !byteDone) begin
            shift <= {shift[6:0], sda};
            bitCnt <= bitCnt + 4'h1;
          end else if (sclFall && byteDone) begin
            bitCnt <= 4'h0;
            if (state == WRITE) begin
              sdaOe <= 1'b1;
              state <= WRITE_ACK;
              ptr <= ptrNext;
            end else if (addrMatch) begin
              sdaOe <= 1'b1;
              readMode <= shift[0];
              state <= ADDR_ACK;
            end else begin
              state <= IDLE;
            end
          end
        end
        WRITE_ACK: begin
          if (sclFall) begin
            sdaOe <= 1'b0;
            state <= WRITE;
          end
        end
        ADDR_ACK: begin
          if (loadByte) begin
            shift <= rdData;
            sdaOe <= !rdData[7];
            bitCnt <= 4'h0;
            ptr <= ptrNext;
            state <= READ;
          end else if (sclFall) begin
            sdaOe <= 1'b0;
            state <= WRITE;
          end
        end
        READ: begin
          if (sclFall) begin
            if (bitCnt == 4'h7) begin
              sdaOe <= 1'b0;
              state <= READ_ACK;
            end else begin
              shift <= {shift[6:0], 1'b0};
              sdaOe <= !shift[6];
              bitCnt <= bitCnt + 4'h1;
            end
          end
        end
        READ_ACK: begin
          if (readNack) begin
            state <= IDLE; // master ends the read
          end else if (loadByte) begin
            shift <= rdData;
            sdaOe <= !rdData[7];
            bitCnt <= 4'h0;
            ptr <= ptrNext;
            state <= READ;
          end
        end
        default: begin
          state <= IDLE;
          sdaOe <= 1'b0;
        end
      endcase
    end
  end
  assign sdaOut = 1'b0;

  // ----------------------------------------------------------------------
  // control and event registers
  // ----------------------------------------------------------------------
  // the identification slot has no storage, so that byte simply vanishes
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      control <= typec_regs_pkg::PORT_CONTROL_RESET;
    end else if (writeCommit &&
                 ptr == typec_regs_pkg::IDX_PORT_CONTROL) begin
      control <= shift;
    end
  end

  // a new event in the clearing cycle survives the clear
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      events <= typec_regs_pkg::EVENTS_RESET;
    end else begin
      events[typec_regs_pkg::EVT_ATTACH] <= attachEvent ||
        (events[typec_regs_pkg::EVT_ATTACH] && !eventsRead);
      events[typec_regs_pkg::EVT_DETACH] <= detachEvent ||
        (events[typec_regs_pkg::EVT_DETACH] && !eventsRead);
    end
  end

  // ----------------------------------------------------------------------
  // outputs to the port logic and interrupt line
  // ----------------------------------------------------------------------
  wire powerSave = control[typec_regs_pkg::CTRL_POWER_SAVE];
  assign lowPower = powerSave;
  assign ccPulldownOnly = powerSave;
  assign trySinkPreferred =
    control[typec_regs_pkg::CTRL_TRY_SINK];
  assign accessoryDetectEnable =
    control[typec_regs_pkg::CTRL_ACCESSORY];
  assign portRole =
    control[typec_regs_pkg::CTRL_ROLE_LSB +: 2];
  assign sourceCurrent = (portRole == typec_regs_pkg::ROLE_SINK) ? 2'h0
    : control[typec_regs_pkg::CTRL_CURRENT_LSB +: 2];
  assign interrupt_request_line_out = 1'b0;
  assign interrupt_request_line_oe = (|events) && !powerSave &&
    !control[typec_regs_pkg::CTRL_INT_MASK];

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  addr_reject_a: assert property (
    (sclFall && state == ADDR && byteDone && !addrMatch) |=> state == IDLE)
    else $error("foreign address was acknowledged");
  start_pointer_a: assert property (
    startDet |=> ptr == typec_regs_pkg::IDX_CHIP_IDENTIFICATION)
    else $error("transfer did not start at first register");
  id_value_a: assert property (
    ptr == typec_regs_pkg::IDX_CHIP_IDENTIFICATION |-> rdData == idValue)
    else $error("identification read wrong");
  id_discard_a: assert property (
    (writeCommit && ptr == typec_regs_pkg::IDX_CHIP_IDENTIFICATION)
    |=> $stable(control))
    else $error("identification write changed control");
  control_write_a: assert property (
    (writeCommit && ptr == typec_regs_pkg::IDX_PORT_CONTROL)
    |=> control == $past(shift) && portRole == $past(shift[2:1]))
    else $error("control write not stored");
  sink_current_a: assert property (
    portRole == typec_regs_pkg::ROLE_SINK |-> sourceCurrent == 2'h0)
    else $error("sink advertises current");
  mask_line_a: assert property (
    control[typec_regs_pkg::CTRL_INT_MASK] |-> !interrupt_request_line_oe)
    else $error("masked interrupt drove line");
  power_save_a: assert property (
    powerSave |-> !interrupt_request_line_oe && lowPower && ccPulldownOnly)
    else $error("low power state not honoured");
  events_reserved_a: assert property (
    ptr == typec_regs_pkg::IDX_ATTACH_DETACH_EVENTS |-> rdData[7:2] == 6'h00)
    else $error("reserved event bits nonzero");
  attach_set_a: assert property (
    attachEvent |=> events[typec_regs_pkg::EVT_ATTACH] ##1
      (events[typec_regs_pkg::EVT_ATTACH] || $past(eventsRead)))
    else $error("attach event lost");
  detach_set_a: assert property (
    detachEvent |=> events[typec_regs_pkg::EVT_DETACH])
    else $error("detach event lost");
  read_clear_a: assert property (
    (eventsRead && !attachEvent && !detachEvent) |=> events == 2'h0)
    else $error("event read did not clear flags");

endmodule

/* src/typec_regs_pkg.sv */
/*
  Constants shared by the plug-in detector register bank: slave address,
  register indices, field positions, reset values and identity codes.
  Assumes a SystemVerilog-2012 compiler; nothing here needs a clock.
*/
package typec_regs_pkg;

  // ----------------------------------------------------------------------
  // bus addressing
  // ----------------------------------------------------------------------
  localparam logic [6:0] SLAVE_ADDR_HIGH = 7'h3d;
  localparam logic [6:0] SLAVE_ADDR_LOW = 7'h1d;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;

  // ----------------------------------------------------------------------
  // register indices (no sub-address byte, access always starts at first)
  // ----------------------------------------------------------------------
  localparam logic [2:0] IDX_CHIP_IDENTIFICATION = 3'h1;
  localparam logic [2:0] IDX_PORT_CONTROL = 3'h2;
  localparam logic [2:0] IDX_ATTACH_DETACH_EVENTS = 3'h3;
  localparam logic [2:0] IDX_CC_STATUS = 3'h4;
  localparam logic [2:0] IDX_LAST = 3'h5;

  // ----------------------------------------------------------------------
  // identification fields; values are arbitrary neutral codes
  // ----------------------------------------------------------------------
  localparam logic [2:0] ID_CHIP_CODE = 3'h5;
  localparam logic [1:0] ID_VERSION_CODE = 2'h1;
  localparam logic [2:0] ID_VENDOR_CODE = 3'h6;
  localparam int ID_CHIP_LSB = 5;
  localparam int ID_VERSION_LSB = 3;

  // ----------------------------------------------------------------------
  // port control fields
  // ----------------------------------------------------------------------
  localparam logic [7:0] PORT_CONTROL_RESET = 8'h00;
  localparam int CTRL_POWER_SAVE = 7;
  localparam int CTRL_TRY_SINK = 6;
  localparam int CTRL_ACCESSORY = 5;
  localparam int CTRL_CURRENT_LSB = 3;
  localparam int CTRL_ROLE_LSB = 1;
  localparam int CTRL_INT_MASK = 0;
  localparam logic [1:0] ROLE_SINK = 2'h0;

  // ----------------------------------------------------------------------
  // event register
  // ----------------------------------------------------------------------
  localparam logic [1:0] EVENTS_RESET = 2'h0;
  localparam int EVT_ATTACH = 0;
  localparam int EVT_DETACH = 1;

endpackage

/* src/sync_two_flop.sv */
/*
  Two-flop synchroniser for a group of independent level signals.
  Assumes each bit is quasi-static relative to clk; bits are not coherent.
*/
`timescale 1ns/10ps
module sync_two_flop #(
  parameter int WIDTH = 1
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [WIDTH-1:0] asyncIn,
  output logic [WIDTH-1:0] syncOut
);

  logic [WIDTH-1:0] stage1;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      stage1 <= '0;
      syncOut <= '0;
    end else begin
      stage1 <= asyncIn;
      syncOut <= stage1;
    end
  end

endmodule

/* testbench/i2c_master_model.sv */
/*
  Behavioural two-wire bus master: start, stop, byte send and byte
  receive with a 1 us bit time, changing data only while the clock is low.
  Assumes the bench resolves the data line with a pull-up and the slave.
*/
`timescale 1ns/10ps
module i2c_master_model (
  output logic scl,
  output logic sdaDrive,
  input wire logic sdaLine
);
  localparam time QUARTER = 250ns;

  initial begin
    scl = 1'b1;
    sdaDrive = 1'b1;
  end

  // ----------------------------------------------------------------------
  // framing
  // ----------------------------------------------------------------------
  // also serves as repeated start, entered with the clock low
  task automatic busStart();
    sdaDrive = 1'b1;
    #QUARTER scl = 1'b1;
    #QUARTER sdaDrive = 1'b0;
    #QUARTER scl = 1'b0;
    #QUARTER;
  endtask

  task automatic busStop();
    sdaDrive = 1'b0;
    #QUARTER scl = 1'b1;
    #QUARTER sdaDrive = 1'b1;
    #QUARTER;
  endtask

  // ----------------------------------------------------------------------
  // bits and bytes
  // ----------------------------------------------------------------------
  task automatic bitCycle(input logic b, output logic seen);
    sdaDrive = b;
    #QUARTER scl = 1'b1;
    #QUARTER seen = sdaLine;
    #QUARTER scl = 1'b0;
    #QUARTER;
  endtask

  task automatic sendByte(input logic [7:0] b, output logic ack);
    logic seen;
    for (int i = 7; i >= 0; i--) begin
      bitCycle(b[i], seen);
    end
    bitCycle(1'b1, seen);
    ack = !seen;
  endtask

  task automatic recvByte(input logic ack, output logic [7:0] b);
    logic seen;
    for (int i = 7; i >= 0; i--) begin
      bitCycle(1'b1, seen);
      b[i] = seen;
    end
    bitCycle(!ack, seen);
  endtask
endmodule

/* testbench/typec_detector_i2c_registers_tb.sv */
/*
  Self-checking bench of the detector register bank, driving the bus
  through the master model and the attach state on the link clock.
  Assumes the design's package is compiled first.
*/
`timescale 1ns/10ps
module typec_detector_i2c_registers_tb;
  logic clk, rstn, linkClk, addressSelect, portAttached;
  logic [7:0] ccStatus;
  logic scl, sdaDrive, sdaLine, sdaOut, sdaOe, irqOut, irqOe;
  logic lowPower, ccPulldownOnly, trySinkPreferred, accessoryDetectEnable;
  logic [1:0] sourceCurrent, portRole;
  logic [7:0] rd [0:5];
  logic [7:0] idExp;
  int fails, compares;

  // pull-up: low only when someone pulls
  assign sdaLine = sdaDrive & !(sdaOe & !sdaOut);
  assign idExp = {typec_regs_pkg::ID_CHIP_CODE,
    typec_regs_pkg::ID_VERSION_CODE, typec_regs_pkg::ID_VENDOR_CODE};

  i2c_master_model i_master (.scl(scl), .sdaDrive(sdaDrive),
    .sdaLine(sdaLine));

  typec_detector_i2c_registers i_dut (.clk(clk), .rstn(rstn),
    .linkClk(linkClk), .sclIn(scl), .sdaIn(sdaLine), .sdaOut(sdaOut),
    .sdaOe(sdaOe), .addressSelect(addressSelect),
    .portAttached(portAttached), .ccStatus(ccStatus),
    .interrupt_request_line_out(irqOut),
    .interrupt_request_line_oe(irqOe), .lowPower(lowPower),
    .ccPulldownOnly(ccPulldownOnly), .trySinkPreferred(trySinkPreferred),
    .accessoryDetectEnable(accessoryDetectEnable),
    .sourceCurrent(sourceCurrent), .portRole(portRole));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  initial begin
    linkClk = 1'b0;
    #7;
    forever #40 linkClk = ~linkClk;
  end

  // ----------------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------------
  task automatic check(input logic [7:0] got, input logic [7:0] exp,
      input string what);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  // no offset byte exists, so every read starts at identification
  task automatic readRegs(input logic [6:0] adr, input int n,
      output logic ack);
    @(negedge clk);
    i_master.busStart();
    i_master.sendByte({adr, 1'b1}, ack);
    for (int i = 0; ack && i < n; i++) begin
      i_master.recvByte(i < n - 1, rd[i]);
    end
    i_master.busStop();
  endtask

  // first byte lands on the identification slot and must vanish
  task automatic writeCtrl(input logic [7:0] ctrl);
    logic a0, a1, a2;
    @(negedge clk);
    i_master.busStart();
    i_master.sendByte({typec_regs_pkg::SLAVE_ADDR_HIGH, 1'b0}, a0);
    i_master.sendByte(~ctrl, a1);
    i_master.sendByte(ctrl, a2);
    i_master.busStop();
    check({5'h0, a0, a1, a2}, 8'h07, "write acks");
  endtask

  task automatic waitLink();
    repeat (6) @(posedge linkClk);
    repeat (4) @(negedge clk);
  endtask

  // ----------------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------------
  task automatic testReset();
    logic ack;
    check({6'h0, portRole}, 8'h00, "role after reset");
    readRegs(typec_regs_pkg::SLAVE_ADDR_HIGH, 6, ack);
    check(rd[0], idExp, "id");
    check(rd[1], 8'h00, "control reset");
    check(rd[2], 8'h00, "events reset");
    check(rd[3], ccStatus, "status");
    check(rd[4], 8'h00, "past end");
    check({7'h0, irqOut}, 8'h00, "irq level");
  endtask

  task automatic testControl();
    logic ack;
    logic [39:0] vals;
    logic [7:0] c;
    vals = {8'h7f, 8'h98, 8'h52, 8'ha5, 8'h00};
    for (int i = 0; i < 5; i++) begin
      c = vals[39 - 8 * i -: 8];
      writeCtrl(c);
      readRegs(typec_regs_pkg::SLAVE_ADDR_HIGH, 2, ack);
      check(rd[0], idExp, "id kept");
      check(rd[1], c, "control");
      check({6'h0, lowPower, ccPulldownOnly}, {6'h0, c[7], c[7]},
        "power save");
      check({7'h0, trySinkPreferred}, {7'h0, c[6]}, "try");
      check({7'h0, accessoryDetectEnable}, {7'h0, c[5]},
        "accessory");
      check({6'h0, sourceCurrent},
        {6'h0, (c[2:1] == 2'h0) ? 2'h0 : c[4:3]}, "current");
      check({6'h0, portRole}, {6'h0, c[2:1]}, "role");
    end
  endtask

  task automatic testAddress();
    logic ack;
    readRegs(typec_regs_pkg::SLAVE_ADDR_LOW, 1, ack);
    check({7'h0, ack}, 8'h00, "low addr strap high");
    @(negedge clk);
    addressSelect = 1'b0;
    repeat (5) @(negedge clk);
    readRegs(typec_regs_pkg::SLAVE_ADDR_LOW, 1, ack);
    check({7'h0, ack}, 8'h01, "low addr strap low");
    check(rd[0], idExp, "id low addr");
    readRegs(typec_regs_pkg::SLAVE_ADDR_HIGH, 1, ack);
    check({7'h0, ack}, 8'h00, "high addr strap low");
    @(negedge clk);
    addressSelect = 1'b1;
    repeat (5) @(negedge clk);
  endtask

  task automatic testEvents();
    logic ack;
    @(negedge linkClk);
    portAttached = 1'b1;
    waitLink();
    check({7'h0, irqOe}, 8'h01, "irq on attach");
    readRegs(typec_regs_pkg::SLAVE_ADDR_HIGH, 3, ack);
    check(rd[2], 8'h01, "attach flag");
    check({7'h0, irqOe}, 8'h00, "irq after read");
    readRegs(typec_regs_pkg::SLAVE_ADDR_HIGH, 3, ack);
    check(rd[2], 8'h00, "cleared");
    writeCtrl(8'h01);
    @(negedge linkClk);
    portAttached = 1'b0;
    waitLink();
    check({7'h0, irqOe}, 8'h00, "irq masked");
    writeCtrl(8'h80);
    check({7'h0, irqOe}, 8'h00, "irq power save");
    writeCtrl(8'h00);
    check({7'h0, irqOe}, 8'h01, "irq unmasked");
    readRegs(typec_regs_pkg::SLAVE_ADDR_HIGH, 3, ack);
    check(rd[2], 8'h02, "detach flag");
    check({7'h0, irqOe}, 8'h00, "irq released");
  endtask

  // ----------------------------------------------------------------------
  // run control
  // ----------------------------------------------------------------------
  task automatic complete_run();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // whole run needs well under 1 ms of bus traffic
  initial begin
    #1500us;
    fails++;
    complete_run();
  end

  initial begin
    rstn = 1'b0;
    addressSelect = 1'b1;
    portAttached = 1'b0;
    ccStatus = 8'h5a;
    fails = 0;
    compares = 0;
    repeat (16) @(posedge clk);
    @(negedge clk);
    rstn = 1'b1;
    repeat (5) @(negedge clk);
    testReset();
    testControl();
    testAddress();
    testEvents();
    complete_run();
  end
endmodule
